// [crf_pkg.sv]
package crf_pkg;
  // Register map, byte addresses on the AHB-Lite slave
  localparam logic [7:0] ADDR_FLAG_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h04;
  localparam logic [7:0] ADDR_CONTROL     = 8'h08;
  localparam logic [7:0] ADDR_COUNTERS    = 8'h0c;
  // Flag status field positions
  localparam int BIT_WAKE    = 7;
  localparam int BIT_CHANGE  = 6;
  localparam int RX_ST_LO    = 4;
  localparam int TX_ST_LO    = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_RXFULL  = 0;
  // Control register: bit 0 init request, bit 1 wake enable
  localparam int BIT_INIT_REQ = 0;
  localparam int BIT_WAKE_EN  = 1;
  // Reset values
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] IEN_RESET  = 8'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Error count thresholds
  localparam logic [8:0] LIM_WARN = 9'd96;
  localparam logic [8:0] LIM_ERR  = 9'd128;
  localparam logic [8:0] LIM_OFF  = 9'd256;
  // Bus-state codes
  localparam logic [1:0] ST_OK   = 2'h0;
  localparam logic [1:0] ST_WARN = 2'h1;
  localparam logic [1:0] ST_ERR  = 2'h2;
  localparam logic [1:0] ST_OFF  = 2'h3;
  // Sensitivity codes
  localparam logic [1:0] SENS_NONE = 2'h0;
  localparam logic [1:0] SENS_OFF  = 2'h1;
  localparam logic [1:0] SENS_ERR  = 2'h2;
  localparam logic [1:0] SENS_ALL  = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam int SYNC_STAGES = 3;
endpackage

// [crf_sync.sv]
module crf_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic din,
  output logic      dout
);
  import crf_pkg::*;
  logic [SYNC_STAGES-1:0] stage_ff;
  logic                   dout_ff;
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_ff <= '0;
      dout_ff  <= 1'b0;
    end else begin
      stage_ff <= {stage_ff[SYNC_STAGES-2:0], din};
      if (stage_ff[1] == stage_ff[2]) begin
        dout_ff <= stage_ff[2];
      end
    end
  end
  assign dout = dout_ff;
endmodule

// [crf_state_dec.sv]
module crf_state_dec (
  input  wire logic [8:0] rx_count,
  input  wire logic [8:0] tx_count,
  output logic      [1:0] rx_code,
  output logic      [1:0] tx_code
);
  import crf_pkg::*;
  wire tx_off = (tx_count >= LIM_OFF);
  // Bus-off overrides the receiver code; once it ends the code follows the receive count again
  assign rx_code = tx_off ? ST_OFF :              // R9 R11
                   (rx_count >= LIM_ERR)  ? ST_ERR :
                   (rx_count >= LIM_WARN) ? ST_WARN : ST_OK;
  assign tx_code = tx_off ? ST_OFF :              // R10
                   (tx_count >= LIM_ERR)  ? ST_ERR :
                   (tx_count >= LIM_WARN) ? ST_WARN : ST_OK;
endmodule

// [crf_top.sv]
// Functional notes
// R1: Write one clears, once cause gone
// R2: Each flag has its enable bit
// R3: Reads always; writes outside init (code also accepts control register writes in init); states read-only
// R4: Init mode holds flags at reset
// R5: Bus-state fields ignore init mode
// R6: Bus activity in sleep sets wake
// R7: Bus state change sets change flag
// R8: States frozen while change flag pending
// R9: Receiver code from receive error count
// R10: Transmitter code from transmit error count
// R11: Bus-off shown in receiver field too
// R12: Overrun sets overrun flag
// R13: Good message to foreground sets full
// R14: Full flag blocks next foreground shift
// R15: Unmasked flags hold the three requests
// R16: Sensitivity fields select counted changes
// R17: Requests are registered flag and enable
// R18: Set wins over same-cycle clear
module crf_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        init_acknowledge,
  input  wire logic        sleep_active,
  input  wire logic        bus_activity,
  input  wire logic [8:0]  rx_err_count,
  input  wire logic [8:0]  tx_err_count,
  input  wire logic        overrun_event,
  input  wire logic        rx_msg_ready,
  output logic             rx_shift_grant,
  output logic             init_request,
  output logic             wake_enable,
  output logic             wake_irq,
  output logic             error_irq,
  output logic             rx_irq
);
  import crf_pkg::*;

  logic        wake_flag_ff, change_flag_ff, ovr_flag_ff, full_flag_ff;
  logic [1:0]  rx_state_ff, tx_state_ff;
  logic [7:0]  ien_ff;
  logic [1:0]  ctrl_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic        grant_ff;
  logic        wake_irq_ff, error_irq_ff, rx_irq_ff;
  logic        activity_sync;
  logic [1:0]  rx_code, tx_code;

  // Bus activity is an asynchronous pin; the rest is same-clock logic
  crf_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (bus_activity),
    .dout    (activity_sync)
  );

  crf_state_dec u_dec (
    .rx_count (rx_err_count),
    .tx_count (tx_err_count),
    .rx_code  (rx_code),
    .tx_code  (tx_code)
  );

  // Sensitivity filter: does moving from old to new state count
  function automatic logic sens_hit(input logic [1:0] sens, input logic [1:0] o,
                                    input logic [1:0] n);
    logic off_edge, err_edge;
    off_edge = (o == ST_OFF) != (n == ST_OFF);
    err_edge = off_edge || ((o == ST_ERR) != (n == ST_ERR));
    case (sens)
      SENS_NONE: sens_hit = 1'b0;
      SENS_OFF:  sens_hit = off_edge;
      SENS_ERR:  sens_hit = err_edge;
      SENS_ALL:  sens_hit = (o != n);
      default:   sens_hit = 1'b0;
    endcase
  endfunction

  // Address phase decode
  wire addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire rd_req   = addr_ok && !hwrite;
  wire in_init  = ctrl_ff[BIT_INIT_REQ] && init_acknowledge;           // R4
  wire wr_flags = wr_pend_ff && (wr_addr_ff == ADDR_FLAG_STATUS) && !in_init; // R3
  wire wr_ien   = wr_pend_ff && (wr_addr_ff == ADDR_IRQ_ENABLE) && !in_init;
  wire wr_ctrl  = wr_pend_ff && (wr_addr_ff == ADDR_CONTROL);
  wire [7:0] w1c = wr_flags ? hwdata[7:0] : 8'h00;                    // R3

  // Flag set conditions
  wire set_wake   = sleep_active && ctrl_ff[BIT_WAKE_EN] && activity_sync; // R6
  wire state_move = (rx_code != rx_state_ff) || (tx_code != tx_state_ff);
  wire set_change = !change_flag_ff && state_move &&                  // R7 R16
                    (sens_hit(ien_ff[5:4], rx_state_ff, rx_code) ||
                     sens_hit(ien_ff[3:2], tx_state_ff, tx_code));
  wire set_ovr    = overrun_event;                                    // R12
  wire take_msg   = rx_msg_ready && !full_flag_ff && grant_ff;        // R13 R14
  wire set_full   = take_msg;

  // Clear only when written one and the cause is gone; set wins
  wire nxt_wake   = set_wake   || (wake_flag_ff   && !(w1c[BIT_WAKE] && !set_wake));  // R1 R18
  wire nxt_change = set_change || (change_flag_ff && !w1c[BIT_CHANGE]);             // R1 R18
  wire nxt_ovr    = set_ovr    || (ovr_flag_ff    && !(w1c[BIT_OVERRUN] && !set_ovr)); // R1 R18
  wire nxt_full   = set_full   || (full_flag_ff   && !w1c[BIT_RXFULL]);             // R1 R18

  // Event flags; held at reset value while init mode is active
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wake_flag_ff, change_flag_ff, ovr_flag_ff, full_flag_ff} <= 4'h0;
    end else if (in_init) begin
      {wake_flag_ff, change_flag_ff, ovr_flag_ff, full_flag_ff} <= 4'h0; // R4
    end else begin
      wake_flag_ff   <= nxt_wake;
      change_flag_ff <= nxt_change;
      ovr_flag_ff    <= nxt_ovr;
      full_flag_ff   <= nxt_full;
    end
  end

  // Bus states follow counters unless a change flag is pending
  wire state_upd = !change_flag_ff;                                   // R8
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_ff <= ST_OK;
      tx_state_ff <= ST_OK;
    end else if (state_upd) begin                                     // R5 R8
      rx_state_ff <= rx_code;
      tx_state_ff <= tx_code;
    end
  end

  // Enable and control registers; enables are cleared in init mode,
  // except the sensitivity fields which survive it
  wire [7:0] ien_keep = ien_ff & 8'h3c;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien_ff  <= IEN_RESET;
      ctrl_ff <= CTRL_RESET;
    end else begin
      if (in_init) begin
        ien_ff <= ien_keep;
      end else if (wr_ien) begin
        ien_ff <= hwdata[7:0];                                        // R2
      end
      if (wr_ctrl) begin
        ctrl_ff <= hwdata[1:0];
      end
    end
  end

  // Foreground shift grant drops once full is set, so no second shift
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grant_ff <= 1'b0;
    end else begin
      grant_ff <= !nxt_full && !in_init;                              // R14
    end
  end

  // Registered interrupt requests, one cycle after flag and enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_irq_ff  <= 1'b0;
      error_irq_ff <= 1'b0;
      rx_irq_ff    <= 1'b0;
    end else begin
      wake_irq_ff  <= wake_flag_ff & ien_ff[BIT_WAKE];                // R15 R17
      error_irq_ff <= (change_flag_ff & ien_ff[BIT_CHANGE]) |         // R15 R17
                      (ovr_flag_ff & ien_ff[BIT_OVERRUN]);
      rx_irq_ff    <= full_flag_ff & ien_ff[BIT_RXFULL];              // R15 R17
    end
  end

  // Read mux, taken in the address phase
  wire [7:0] flag_view = {wake_flag_ff, change_flag_ff, rx_state_ff, tx_state_ff,
                          ovr_flag_ff, full_flag_ff};
  wire [31:0] rd_mux =
    (haddr == ADDR_FLAG_STATUS) ? {24'h000000, flag_view} :
    (haddr == ADDR_IRQ_ENABLE)  ? {24'h000000, ien_ff} :
    (haddr == ADDR_CONTROL)     ? {30'h00000000, ctrl_ff} :
    (haddr == ADDR_COUNTERS)    ? {7'h00, tx_err_count, 7'h00, rx_err_count} :
    32'h00000000;

  // Zero wait state slave; write data lands one cycle after address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff  <= 32'h00000000;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      wr_addr_ff <= haddr;
      if (rd_req) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  assign hrdata         = hrdata_ff;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign rx_shift_grant = grant_ff;
  assign init_request   = ctrl_ff[BIT_INIT_REQ];
  assign wake_enable    = ctrl_ff[BIT_WAKE_EN];
  assign wake_irq       = wake_irq_ff;
  assign error_irq      = error_irq_ff;
  assign rx_irq         = rx_irq_ff;

  property p_set_wins;
    @(posedge hclk) disable iff (!hresetn)
      (set_ovr && !in_init) |=> ovr_flag_ff;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overrun set lost"); // R18

  property p_init_hold;
    @(posedge hclk) disable iff (!hresetn)
      in_init |=> !(wake_flag_ff || change_flag_ff || ovr_flag_ff || full_flag_ff);
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("flags not held in init"); // R4

  property p_freeze;
    @(posedge hclk) disable iff (!hresetn)
      change_flag_ff |=> $stable(rx_state_ff) && $stable(tx_state_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while pending"); // R8

  property p_rx_irq;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> rx_irq_ff == $past(full_flag_ff & ien_ff[BIT_RXFULL]);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx request wrong"); // R17

  property p_no_shift_full;
    @(posedge hclk) disable iff (!hresetn)
      full_flag_ff |-> !grant_ff;
  endproperty
  a_no_shift_full: assert property (p_no_shift_full) else $error("shift while full"); // R14

  sequence s_busoff;
    tx_err_count >= LIM_OFF;
  endsequence
  property p_busoff_rx;
    @(posedge hclk) disable iff (!hresetn)
      s_busoff |-> rx_code == ST_OFF;
  endproperty
  a_busoff_rx: assert property (p_busoff_rx) else $error("bus-off not in rx code"); // R11

  property p_tx_warn;
    @(posedge hclk) disable iff (!hresetn)
      (tx_err_count >= LIM_WARN && tx_err_count < LIM_ERR) |-> tx_code == ST_WARN;
  endproperty
  a_tx_warn: assert property (p_tx_warn) else $error("tx warning code wrong"); // R10

  property p_wake_set;
    @(posedge hclk) disable iff (!hresetn)
      (set_wake && !in_init) |=> wake_flag_ff ##1 wake_irq_ff == $past(ien_ff[BIT_WAKE]);
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake flag not set"); // R6

  property p_w1c_full;
    @(posedge hclk) disable iff (!hresetn)
      (wr_flags && hwdata[BIT_RXFULL] && !set_full) |=> !full_flag_ff;
  endproperty
  a_w1c_full: assert property (p_w1c_full) else $error("full flag not cleared"); // R1

  property p_zero_write;
    @(posedge hclk) disable iff (!hresetn)
      (wr_flags && !hwdata[BIT_OVERRUN] && ovr_flag_ff) |=> ovr_flag_ff;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write cleared flag"); // R3

  property p_irq_drop;
    @(posedge hclk) disable iff (!hresetn)
      !wake_flag_ff |=> !wake_irq_ff;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("wake request outlived flag"); // R17

  // Any receiver move under full sensitivity outside init mode must raise the change flag
  sequence s_rx_any_move;
    !change_flag_ff && !in_init && (ien_ff[5:4] == SENS_ALL) && (rx_code != rx_state_ff);
  endsequence
  property p_change_set;
    @(posedge hclk) disable iff (!hresetn)
      s_rx_any_move |=> change_flag_ff;
  endproperty
  a_change_set: assert property (p_change_set) else $error("change flag missed"); // R7

  property p_sens_none;
    @(posedge hclk) disable iff (!hresetn)
      (ien_ff[5:2] == 4'h0 && !change_flag_ff) |=> !change_flag_ff;
  endproperty
  a_sens_none: assert property (p_sens_none) else $error("change flag unasked"); // R16

  property p_state_track;
    @(posedge hclk) disable iff (!hresetn)
      !change_flag_ff |=> rx_state_ff == $past(rx_code) && tx_state_ff == $past(tx_code);
  endproperty
  a_state_track: assert property (p_state_track) else $error("bus state not tracking"); // R5
endmodule

// [crf_engine_model.sv]
module crf_engine_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       init_request,
  input  wire logic       rx_shift_grant,
  input  wire logic       push,
  output logic            init_acknowledge,
  output logic            rx_msg_ready,
  output logic      [3:0] depth_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // Queue offers a message whenever one is waiting
  assign rx_msg_ready = (depth_ff != 4'h0);
  // Ack trails the request by a cycle; a shift only leaves on grant
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_acknowledge <= 1'b0;
      depth_ff         <= 4'h0;
    end else begin
      init_acknowledge <= init_request;
      depth_ff <= depth_ff + {3'h0, push} - {3'h0, rx_msg_ready && rx_shift_grant};
    end
  end
endmodule

// [testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import crf_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, push;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        init_acknowledge, sleep_active, bus_activity, overrun_event, rx_msg_ready;
  logic        rx_shift_grant, init_request, wake_enable, wake_irq, error_irq, rx_irq;
  logic [8:0]  rx_err_count, tx_err_count;
  logic [3:0]  depth_ff;
  int          num_errors, total_checks;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  crf_top i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .init_acknowledge, .sleep_active, .bus_activity,
    .rx_err_count, .tx_err_count, .overrun_event, .rx_msg_ready, .rx_shift_grant,
    .init_request, .wake_enable, .wake_irq, .error_irq, .rx_irq
  );
  crf_engine_model i_eng (
    .hclk, .hresetn, .init_request, .rx_shift_grant, .push,
    .init_acknowledge, .rx_msg_ready, .depth_ff
  );
  // 125 MHz clock
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Single word transfer; caller stands just after an edge, no fixed latency assumed
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    cyc(20000);
    num_errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, push, sleep_active, bus_activity, overrun_event} = '0;
    {haddr, htrans, hsize, hwdata, rx_err_count, tx_err_count} = '0;
    cyc(16);
    hresetn <= 1'b1;
    cyc(1);
    rdc(ADDR_FLAG_STATUS, 32'h0);
    rdc(ADDR_IRQ_ENABLE, 32'h0);
    rdc(8'h10, 32'h0);
    // Two messages queued; the second must wait for the clear
    wr(ADDR_IRQ_ENABLE, 32'h03);
    push <= 1'b1;
    cyc(2);
    push <= 1'b0;
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h01);
    chk({28'h0, depth_ff}, 32'h1);
    chk({31'h0, rx_shift_grant}, 32'h0);
    chk({31'h0, rx_irq}, 32'h1);
    wr(ADDR_FLAG_STATUS, 32'h01);
    cyc(4);
    chk({28'h0, depth_ff}, 32'h0);
    rdc(ADDR_FLAG_STATUS, 32'h01);
    wr(ADDR_FLAG_STATUS, 32'h01);
    cyc(2);
    rdc(ADDR_FLAG_STATUS, 32'h0);
    chk({31'h0, rx_irq}, 32'h0);
    chk({31'h0, rx_shift_grant}, 32'h1);
    // Overrun held present: zero write and early clear both refused
    overrun_event <= 1'b1;
    cyc(3);
    rdc(ADDR_FLAG_STATUS, 32'h02);
    chk({31'h0, error_irq}, 32'h1);
    wr(ADDR_FLAG_STATUS, 32'h0);
    rdc(ADDR_FLAG_STATUS, 32'h02);
    wr(ADDR_FLAG_STATUS, 32'h02);
    rdc(ADDR_FLAG_STATUS, 32'h02);
    overrun_event <= 1'b0;
    cyc(2);
    wr(ADDR_FLAG_STATUS, 32'h02);
    rdc(ADDR_FLAG_STATUS, 32'h0);
    // Bus states; sensitivity none first, then every change
    rx_err_count <= 9'd100;
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h10);
    wr(ADDR_IRQ_ENABLE, 32'hff);
    rx_err_count <= 9'd130;
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h60);
    chk({31'h0, error_irq}, 32'h1);
    rx_err_count <= 9'd60;
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h60);
    wr(ADDR_FLAG_STATUS, 32'h40);
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h40);
    wr(ADDR_FLAG_STATUS, 32'h40);
    rdc(ADDR_FLAG_STATUS, 32'h0);
    tx_err_count <= 9'd256;
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h7c);
    tx_err_count <= 9'd0;
    cyc(4);
    wr(ADDR_FLAG_STATUS, 32'h40);
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h40);
    wr(ADDR_FLAG_STATUS, 32'h40);
    // Wake on bus activity while asleep
    wr(ADDR_CONTROL, 32'h02);
    sleep_active <= 1'b1;
    bus_activity <= 1'b1;
    cyc(2);
    bus_activity <= 1'b0;
    chk({31'h0, wake_enable}, 32'h1);
    cyc(6);
    rdc(ADDR_FLAG_STATUS, 32'h80);
    chk({31'h0, wake_irq}, 32'h1);
    sleep_active <= 1'b0;
    wr(ADDR_FLAG_STATUS, 32'h80);
    rdc(ADDR_FLAG_STATUS, 32'h0);
    // Init mode clears flags and enables except the sensitivity fields, and keeps states tracking
    overrun_event <= 1'b1;
    cyc(1);
    overrun_event <= 1'b0;
    cyc(3);
    wr(ADDR_CONTROL, 32'h01);
    cyc(4);
    chk({31'h0, init_request}, 32'h1);
    rdc(ADDR_CONTROL, 32'h01);
    rdc(ADDR_FLAG_STATUS, 32'h0);
    rdc(ADDR_IRQ_ENABLE, 32'h3c);
    tx_err_count <= 9'd100;
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h04);
    wr(ADDR_IRQ_ENABLE, 32'h01);
    rdc(ADDR_IRQ_ENABLE, 32'h3c);
    wr(ADDR_CONTROL, 32'h0);
    cyc(4);
    chk({31'h0, init_request}, 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h01);
    rdc(ADDR_IRQ_ENABLE, 32'h01);
    rdc(ADDR_COUNTERS, 32'h0064003c);
    // Narrow sensitivities: bus-off only on tx, then error level on rx
    wr(ADDR_IRQ_ENABLE, 32'h04);
    tx_err_count <= 9'd130;
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h08);
    tx_err_count <= 9'd256;
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h7c);
    chk({31'h0, error_irq}, 32'h0);
    tx_err_count <= 9'd130;
    cyc(4);
    wr(ADDR_FLAG_STATUS, 32'h40);
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h48);
    wr(ADDR_FLAG_STATUS, 32'h40);
    wr(ADDR_IRQ_ENABLE, 32'h20);
    rx_err_count <= 9'd100;
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h18);
    rx_err_count <= 9'd130;
    cyc(4);
    rdc(ADDR_FLAG_STATUS, 32'h68);
    complete_run();
  end
endmodule
